// [logic/nvc_controller.sv]
// Serial nonvolatile memory access controller: two register ports, ROM window, boot read
// ----------------------------------------------------------------
// How it works
// - ROM window read fetches four memory bytes and packs them into one word.
// - ROM window writes are acknowledged and their data thrown away.
// - Control register at 3Ch: command 31:29, fail 28, address/data 23:16.
// - First window read gets Retry and starts fetch at address bits 10:2 with bits 1:0 cleared.
// - Once fetched, only the same address completes, with target ready and data.
// - Other addresses or early repeats of the window read get Retry again.
// - Stuck window fetch blocks window reads only; both registers keep working.
// - Window covers a 2K region mapped straight onto the memory.
// - After reset release, memory bytes 40h to 7Fh are read automatically.
// - Command 0xx dummy (selects write data), 100 low address, 101 high address, 110 write, 111 read.
// - Begin read or write sets bit 31 busy until the operation ends.
// - Command and byte may come in one write or in two separate writes.
// - Only one of the low, high and write-data load selects is active.
// - Data writes overwrite the address or write-data byte chosen by the active select.
// - Address is 11 bits; only three low bits of the high byte kept.
// - Dummy command selects write data loading until another command arrives.
// - Begin write drops data select, sets busy and writes the stored byte.
// - Missing acknowledge sets bit 28 until the next operation starts.
// - After a write, poll the memory until it acknowledges, then clear busy.
// - Add-on register behaves like the host one, with extra retiming latency.
// - Commands from both sides queue; no guard against mutual overwrites.
// - Finished read shows the memory byte in bits 23:16.
// - Serial clock is the core clock divided by 293.
// - Memory addressed with address bits 10:8 in the strap bit positions; sole master, no arbitration.
// - Clock and data lines released whenever no memory access runs.
// ----------------------------------------------------------------
`timescale 1ns/1ps
module nvc_controller (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire nvc_pkg::nvc_req_t host_req,
	output logic [31:0] host_rdata,
	input wire nvc_pkg::nvc_req_t addon_req,
	output logic [31:0] addon_rdata,
	input wire logic rom_enable,
	input wire logic [31:0] rom_base,
	input wire nvc_pkg::nvc_rom_req_t rom_req,
	output logic rom_retry,
	output logic rom_trdy,
	output logic rom_wr_ack,
	output logic [31:0] rom_data,
	output logic cfg_valid,
	output logic [6:0] cfg_addr,
	output logic [7:0] cfg_data,
	output logic boot_done,
	output logic boot_fail,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe
);
	import nvc_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		nvc_side_t host;
		nvc_side_t addon;
		nvc_req_t addon_d1;
		nvc_req_t addon_d2;
		logic [31:0] host_rdata;
		logic [31:0] addon_rdata;
		nvc_src_t [2:0] q;
		logic [1:0] qn;
		nvc_eng_t eng;
		nvc_step_t step;
		nvc_src_t src;
		logic [8:0] cnt;
		logic [3:0] bitn;
		logic [7:0] sh;
		logic rxbit;
		logic again;
		logic op_rd;
		logic [10:0] addr;
		logic [7:0] wbyte;
		logic [6:0] left;
		logic [1:0] bidx;
		nvc_rom_t rom_st;
		logic [31:0] rom_la;
		logic [3:0][7:0] rom_buf;
		logic rom_retry;
		logic rom_trdy;
		logic rom_wr_ack;
		logic boot_act;
		logic boot_done;
		logic boot_fail;
		logic cfg_valid;
		logic [6:0] cfg_addr;
		logic [7:0] cfg_data;
		logic scl_oe;
		logic sda_oe;
	} nvc_state_t;

	nvc_state_t r;
	nvc_state_t n;
	logic host_go;
	logic addon_go;
	logic rom_go;
	logic rom_hit;
	logic sym_end;
	logic [1:0] qi;

	// ----------------------------------------------------------------
	// Register port helpers, shared by both sides
	// ----------------------------------------------------------------
	// Command decode first, then the data lane under the new select
	function automatic nvc_side_t side_write(nvc_side_t s, nvc_req_t q);
		nvc_side_t o;
		logic [2:0] cmd;
		logic [7:0] d;
		o = s;
		cmd = q.data[NVC_CMD_HI:NVC_CMD_LO];
		d = q.data[NVC_DATA_HI:NVC_DATA_LO];
		if (q.wr && q.addr == NVC_REG_OFS) begin
			if (q.be[NVC_CMD_LANE]) begin
				if (!cmd[2]) begin
					o.sel = SEL_WDATA;
				end else begin
					unique case (cmd)
						NVC_CMD_LOAD_LO: o.sel = SEL_LO;
						NVC_CMD_LOAD_HI: o.sel = SEL_HI;
						NVC_CMD_BEGIN_WR: begin
							o.sel = SEL_NONE;
							if (!s.busy) begin
								if (q.be[NVC_DATA_LANE]) begin
									o.wdata = d;
								end
								o.busy = 1'b1;
								o.op_rd = 1'b0;
							end
						end
						NVC_CMD_BEGIN_RD: begin
							o.sel = SEL_NONE;
							if (!s.busy) begin
								o.busy = 1'b1;
								o.op_rd = 1'b1;
							end
						end
					endcase
				end
			end
			if (q.be[NVC_DATA_LANE]) begin
				unique case (o.sel)
					SEL_LO: o.addr_lo = d;
					SEL_HI: o.addr_hi = d[NVC_HI_BITS-1:0];
					SEL_WDATA: o.wdata = d;
					SEL_NONE: o.sel = SEL_NONE;
				endcase
			end
		end
		return o;
	endfunction

	// Status word; bits 30:29 and the unused bits read as zero
	function automatic logic [31:0] side_word(nvc_side_t s);
		logic [31:0] w;
		w = '0;
		w[NVC_BUSY_BIT] = s.busy;
		w[NVC_FAIL_BIT] = s.fail;
		w[NVC_DATA_HI:NVC_DATA_LO] = s.rdata;
		return w;
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		n = r;
		qi = 2'h0;
		n.rom_retry = 1'b0;
		n.rom_trdy = 1'b0;
		n.rom_wr_ack = 1'b0;
		n.cfg_valid = 1'b0;

		// Add-on requests pass two retiming stages before use
		n.addon_d1 = addon_req;
		n.addon_d2 = r.addon_d1;
		n.host = side_write(r.host, host_req);
		n.addon = side_write(r.addon, r.addon_d2);
		host_go = n.host.busy && !r.host.busy;
		addon_go = n.addon.busy && !r.addon.busy;
		if (host_req.rd) begin
			n.host_rdata = (host_req.addr == NVC_REG_OFS) ? side_word(r.host) : '0;
		end
		if (r.addon_d2.rd) begin
			n.addon_rdata = (r.addon_d2.addr == NVC_REG_OFS) ? side_word(r.addon) : '0;
		end

		// Expansion ROM window: only a hit inside the 2K region is served
		rom_hit = rom_enable &&
			rom_req.addr[31:NVC_ROM_AW] == rom_base[31:NVC_ROM_AW];
		rom_go = 1'b0;
		if (rom_hit && rom_req.wr) begin
			n.rom_wr_ack = 1'b1;
		end
		if (rom_hit && rom_req.rd) begin
			unique case (r.rom_st)
				ROM_IDLE: begin
					n.rom_retry = 1'b1;
					n.rom_la = rom_req.addr;
					n.rom_st = ROM_FETCH;
					rom_go = 1'b1;
				end
				ROM_FETCH: n.rom_retry = 1'b1;
				ROM_READY: begin
					if (rom_req.addr == r.rom_la) begin
						n.rom_trdy = 1'b1;
						n.rom_st = ROM_IDLE;
					end else begin
						n.rom_retry = 1'b1;
					end
				end
				default: n.rom_st = ROM_IDLE;
			endcase
		end

		// Arrival queue; the engine takes its head when free
		if (r.eng == ENG_IDLE && !r.boot_act && r.qn != 2'h0) begin
			n.src = r.q[0];
			n.q[0] = r.q[1];
			n.q[1] = r.q[2];
			n.qn = r.qn - 2'h1;
			n.eng = ENG_START;
			n.step = STEP_CTRL_W;
			n.cnt = '0;
			n.again = 1'b0;
			unique case (r.q[0])
				SRC_HOST: begin
					n.addr = {r.host.addr_hi, r.host.addr_lo};
					n.wbyte = r.host.wdata;
					n.op_rd = r.host.op_rd;
					n.left = NVC_REG_LEN;
					n.host.fail = 1'b0;
				end
				SRC_ADDON: begin
					n.addr = {r.addon.addr_hi, r.addon.addr_lo};
					n.wbyte = r.addon.wdata;
					n.op_rd = r.addon.op_rd;
					n.left = NVC_REG_LEN;
					n.addon.fail = 1'b0;
				end
				default: begin
					n.addr = {r.rom_la[NVC_ROM_AW-1:2], 2'b00};
					n.op_rd = 1'b1;
					n.left = NVC_ROM_LEN;
					n.bidx = 2'h0;
				end
			endcase
		end
		qi = n.qn;
		if (host_go) begin
			n.q[qi] = SRC_HOST;
			qi = qi + 2'h1;
		end
		if (addon_go) begin
			n.q[qi] = SRC_ADDON;
			qi = qi + 2'h1;
		end
		if (rom_go) begin
			n.q[qi] = SRC_ROM;
			qi = qi + 2'h1;
		end
		n.qn = qi;

		// Serial engine: each symbol spans one divided clock period
		sym_end = r.cnt == NVC_SCL_LAST;
		if (r.eng != ENG_IDLE) begin
			n.cnt = sym_end ? '0 : r.cnt + 9'h001;
		end
		unique case (r.eng)
			ENG_IDLE: begin
				n.scl_oe = 1'b0;
				n.sda_oe = 1'b0;
			end
			ENG_START: begin
				n.scl_oe = r.cnt < NVC_SCL_QTR;
				n.sda_oe = r.cnt >= NVC_SCL_HALF;
				if (sym_end) begin
					n.eng = ENG_BIT;
					n.bitn = '0;
					n.sh = {NVC_DEV_TYPE, r.addr[10:8], r.step == STEP_CTRL_R};
				end
			end
			ENG_BIT: begin
				n.scl_oe = r.cnt < NVC_SCL_HALF;
				// Data moves only a quarter period into the low phase
				if (r.cnt >= NVC_SCL_QTR) begin
					if (r.bitn < NVC_ACK_SLOT) begin
						n.sda_oe = r.step != STEP_READ && !r.sh[7];
					end else begin
						n.sda_oe = r.step == STEP_READ && r.left != NVC_REG_LEN;
					end
				end
				if (r.cnt == NVC_SCL_SAMPLE) begin
					n.rxbit = sda_in;
				end
				if (sym_end && r.bitn < NVC_ACK_SLOT) begin
					n.sh = {r.sh[6:0], r.rxbit};
					n.bitn = r.bitn + 4'h1;
				end else if (sym_end) begin
					n.bitn = '0;
					if (r.step == STEP_READ) begin
						n.addr = r.addr + 11'h001;
						n.left = r.left - 7'h01;
						n.eng = (r.left == NVC_REG_LEN) ? ENG_STOP : ENG_BIT;
						unique case (r.src)
							SRC_HOST: n.host.rdata = r.sh;
							SRC_ADDON: n.addon.rdata = r.sh;
							SRC_ROM: begin
								n.rom_buf[r.bidx] = r.sh;
								n.bidx = r.bidx + 2'h1;
							end
							SRC_BOOT: begin
								n.cfg_valid = 1'b1;
								n.cfg_addr = r.addr[6:0];
								n.cfg_data = r.sh;
							end
						endcase
					end else if (r.rxbit) begin
						n.eng = ENG_STOP;
						if (r.step == STEP_POLL) begin
							n.again = 1'b1;
						end else begin
							unique case (r.src)
								SRC_HOST: n.host.fail = 1'b1;
								SRC_ADDON: n.addon.fail = 1'b1;
								SRC_BOOT: n.boot_fail = 1'b1;
								SRC_ROM: n.again = 1'b0;
							endcase
						end
					end else begin
						unique case (r.step)
							STEP_CTRL_W: begin
								n.step = STEP_ADDR;
								n.sh = r.addr[7:0];
							end
							STEP_ADDR: begin
								if (r.op_rd) begin
									n.step = STEP_CTRL_R;
									n.eng = ENG_START;
								end else begin
									n.step = STEP_DATA;
									n.sh = r.wbyte;
								end
							end
							STEP_DATA: begin
								n.eng = ENG_STOP;
								n.again = 1'b1;
							end
							STEP_CTRL_R: n.step = STEP_READ;
							STEP_POLL: n.eng = ENG_STOP;
							default: n.eng = ENG_STOP;
						endcase
					end
				end
			end
			ENG_STOP: begin
				n.scl_oe = r.cnt < NVC_SCL_HALF;
				n.sda_oe = (r.cnt < NVC_SCL_QTR) ? r.sda_oe : r.cnt < NVC_SCL_SAMPLE;
				if (sym_end && r.again) begin
					n.again = 1'b0;
					n.step = STEP_POLL;
					n.eng = ENG_START;
				end else if (sym_end) begin
					n.eng = ENG_IDLE;
					unique case (r.src)
						SRC_HOST: n.host.busy = 1'b0;
						SRC_ADDON: n.addon.busy = 1'b0;
						SRC_ROM: n.rom_st = ROM_READY;
						SRC_BOOT: begin
							n.boot_act = 1'b0;
							n.boot_done = 1'b1;
						end
					endcase
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// State register; reset launches the boot read at once
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
			r.eng <= ENG_START;
			r.src <= SRC_BOOT;
			r.step <= STEP_CTRL_W;
			r.addr <= NVC_BOOT_FIRST;
			r.left <= NVC_BOOT_LEN;
			r.op_rd <= 1'b1;
			r.boot_act <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// Outputs straight from the state register; pins only ever pull low
	assign host_rdata = r.host_rdata;
	assign addon_rdata = r.addon_rdata;
	assign rom_retry = r.rom_retry;
	assign rom_trdy = r.rom_trdy;
	assign rom_wr_ack = r.rom_wr_ack;
	assign rom_data = r.rom_buf;
	assign cfg_valid = r.cfg_valid;
	assign cfg_addr = r.cfg_addr;
	assign cfg_data = r.cfg_data;
	assign boot_done = r.boot_done;
	assign boot_fail = r.boot_fail;
	assign scl_out = r.op_rd & 1'b0;
	assign scl_oe = r.scl_oe;
	assign sda_out = r.op_rd & 1'b0;
	assign sda_oe = r.sda_oe;

endmodule

// [logic/nvc_pkg.sv]
// Package for the serial nonvolatile memory access controller: constants, types
package nvc_pkg;

	// ----------------------------------------------------------------
	// Register map and field layout
	// ----------------------------------------------------------------
	localparam logic [7:0] NVC_REG_OFS = 8'h3C;
	localparam int NVC_BUSY_BIT = 31;
	localparam int NVC_CMD_HI = 31;
	localparam int NVC_CMD_LO = 29;
	localparam int NVC_FAIL_BIT = 28;
	localparam int NVC_DATA_HI = 23;
	localparam int NVC_DATA_LO = 16;
	localparam int NVC_CMD_LANE = 3;
	localparam int NVC_DATA_LANE = 2;
	localparam int NVC_HI_BITS = 3;
	localparam int NVC_ROM_AW = 11;

	// Commands in bits 31:29; any code with bit 31 clear is the dummy command
	localparam logic [2:0] NVC_CMD_LOAD_LO = 3'h4;
	localparam logic [2:0] NVC_CMD_LOAD_HI = 3'h5;
	localparam logic [2:0] NVC_CMD_BEGIN_WR = 3'h6;
	localparam logic [2:0] NVC_CMD_BEGIN_RD = 3'h7;

	// ----------------------------------------------------------------
	// Serial link timing and framing
	// ----------------------------------------------------------------
	localparam logic [8:0] NVC_SCL_DIV = 9'h125;
	localparam logic [8:0] NVC_SCL_LAST = NVC_SCL_DIV - 9'h001;
	localparam logic [8:0] NVC_SCL_QTR = NVC_SCL_DIV >> 2;
	localparam logic [8:0] NVC_SCL_HALF = NVC_SCL_DIV >> 1;
	localparam logic [8:0] NVC_SCL_SAMPLE = NVC_SCL_HALF + NVC_SCL_QTR;
	localparam logic [3:0] NVC_ACK_SLOT = 4'h8;
	localparam logic [3:0] NVC_DEV_TYPE = 4'hA;
	localparam logic [10:0] NVC_BOOT_FIRST = 11'h040;
	localparam logic [6:0] NVC_BOOT_LEN = 7'h40;
	localparam logic [6:0] NVC_ROM_LEN = 7'h04;
	localparam logic [6:0] NVC_REG_LEN = 7'h01;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {SEL_NONE, SEL_LO, SEL_HI, SEL_WDATA} nvc_sel_t;
	typedef enum logic [1:0] {SRC_HOST, SRC_ADDON, SRC_ROM, SRC_BOOT} nvc_src_t;
	typedef enum logic [1:0] {ENG_IDLE, ENG_START, ENG_BIT, ENG_STOP} nvc_eng_t;
	typedef enum logic [2:0] {
		STEP_CTRL_W, STEP_ADDR, STEP_DATA, STEP_CTRL_R, STEP_READ, STEP_POLL
	} nvc_step_t;
	typedef enum logic [1:0] {ROM_IDLE, ROM_FETCH, ROM_READY} nvc_rom_t;

	// One register access port: host side and add-on side alike
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [3:0] be;
		logic [31:0] data;
	} nvc_req_t;

	// Decoded expansion ROM window cycle from the bus target
	typedef struct packed {
		logic rd;
		logic wr;
		logic [31:0] addr;
	} nvc_rom_req_t;

	// Per-side access control register state
	typedef struct packed {
		nvc_sel_t sel;
		logic [7:0] addr_lo;
		logic [NVC_HI_BITS-1:0] addr_hi;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic busy;
		logic fail;
		logic op_rd;
	} nvc_side_t;

endpackage

// [tb/nvc_checker.sv]
// Port assertions for the serial memory access controller
`timescale 1ns/1ps
module nvc_checker (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire nvc_pkg::nvc_req_t host_req,
	input wire logic [31:0] host_rdata,
	input wire nvc_pkg::nvc_req_t addon_req,
	input wire logic [31:0] addon_rdata,
	input wire logic rom_enable,
	input wire logic [31:0] rom_base,
	input wire nvc_pkg::nvc_rom_req_t rom_req,
	input wire logic rom_retry,
	input wire logic rom_trdy,
	input wire logic rom_wr_ack,
	input wire logic cfg_valid,
	input wire logic [6:0] cfg_addr,
	input wire logic scl_oe
);
	import nvc_pkg::*;
	logic hit;
	logic [8:0] lo_reg;
	logic [8:0] lo_next;
	// --------
	// Helpers
	// --------
	// Window decode, as the bus target sees it
	assign hit = rom_enable && rom_req.addr[31:11] == rom_base[31:11];
	// Length of the current clock-low stretch; cleared whenever the clock is released
	always_comb begin
		lo_next = scl_oe ? lo_reg + 9'h001 : 9'h000;
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			lo_reg <= 9'h000;
		end else begin
			lo_reg <= lo_next;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// --------
	// Assertions
	// --------
	a_rom_retry_cause: assert property (rom_retry |-> $past(rom_req.rd) && $past(hit))
		else $error("retry without a window read");
	a_rom_trdy_cause: assert property (rom_trdy |-> $past(rom_req.rd) && !rom_retry)
		else $error("target ready without a window read");
	a_rom_wr_drop: assert property (rom_req.wr && hit |=> rom_wr_ack && !rom_trdy)
		else $error("window write not accepted");
	a_rom_rd_answer: assert property (rom_req.rd && hit |=> rom_retry != rom_trdy)
		else $error("window read not answered once");
	a_scl_low_time: assert property ($fell(scl_oe) |->
		lo_reg == NVC_SCL_HALF || lo_reg == NVC_SCL_QTR)
		else $error("serial clock low time wrong");
	a_boot_range: assert property (cfg_valid |-> cfg_addr[6])
		else $error("boot byte outside 40h to 7Fh");
	a_host_unmapped: assert property (host_req.rd && host_req.addr != NVC_REG_OFS |=>
		host_rdata == 32'h0) else $error("unmapped host read not zero");
	a_addon_unmapped: assert property (addon_req.rd && addon_req.addr != NVC_REG_OFS |->
		##3 addon_rdata == 32'h0) else $error("unmapped add-on read not zero");
	a_rdata_hold: assert property (!$past(host_req.rd) |-> $stable(host_rdata))
		else $error("host read word changed without a read");
	a_field_layout: assert property (host_rdata[27:24] == 4'h0 && host_rdata[15:0] == 16'h0)
		else $error("reserved bits set in host read word");
	c_rom_done: cover property (rom_trdy);
	c_busy_clear: cover property ($fell(host_rdata[31]));
	c_rom_write: cover property (rom_wr_ack);
endmodule
bind nvc_controller nvc_checker u_nvc_checker (.core_clk(core_clk), .rst_n(rst_n),
	.host_req(host_req), .host_rdata(host_rdata), .addon_req(addon_req),
	.addon_rdata(addon_rdata), .rom_enable(rom_enable), .rom_base(rom_base),
	.rom_req(rom_req), .rom_retry(rom_retry), .rom_trdy(rom_trdy), .rom_wr_ack(rom_wr_ack),
	.cfg_valid(cfg_valid), .cfg_addr(cfg_addr), .scl_oe(scl_oe));

// [tb/nvc_mem_model.sv]
// Behavioural two-wire serial memory facing the controller
`timescale 1ns/1ps
module nvc_mem_model #(
	parameter int WR_NS = 40000
) (
	input wire logic scl,
	input wire logic sda,
	input wire logic nak_all,
	output logic sda_pull
);
	logic [7:0] mem [0:2047];
	logic [7:0] sh = 8'h00;
	logic [10:0] ptr = 11'h000;
	logic rd_mode = 1'b0;
	logic wrote = 1'b0;
	logic wr_busy = 1'b0;
	logic ack = 1'b0;
	int b = -1;
	int phase = 0;
	// Known contents so every read has a value to compare against
	initial begin
		sda_pull = 1'b0;
		for (int i = 0; i < 2048; i++) begin
			mem[i] = i[7:0] ^ 8'hA5;
		end
	end
	// Start: data falls with the clock high
	always @(negedge sda) begin
		if (scl === 1'b1) begin
			b = -1;
			phase = 0;
			rd_mode = 1'b0;
		end
	end
	// Stop: a finished write keeps the array deaf for the write time
	always @(posedge sda) begin
		if (scl === 1'b1) begin
			if (wrote) begin
				wr_busy = 1'b1;
				wr_busy <= #(WR_NS) 1'b0;
			end
			wrote = 1'b0;
			b = -1;
			phase = 0;
			rd_mode = 1'b0;
		end
	end
	// Shift in on the rising clock; a master no-acknowledge ends a read
	always @(posedge scl) begin
		if (b >= 0 && b < 8 && !rd_mode) begin
			sh = {sh[6:0], sda};
		end
		if (b == 8 && rd_mode && sda) begin
			rd_mode = 1'b0;
		end
	end
	// Drive acknowledge and read bits while the clock is low
	always @(negedge scl) begin
		if (b == 8) begin
			b = 0;
			sda_pull = rd_mode ? ~mem[ptr][7] : 1'b0;
		end else if (b >= -1) begin
			b = b + 1;
			if (b == 8 && rd_mode) begin
				sda_pull = 1'b0;
				ptr = ptr + 11'h001;
			end else if (b == 8) begin
				ack = 1'b1;
				if (phase == 0) begin
					ack = sh[7:4] == 4'hA && !nak_all && !wr_busy;
					ptr[10:8] = sh[3:1];
					rd_mode = ack && sh[0];
				end else if (phase == 1) begin
					ptr[7:0] = sh;
				end else begin
					mem[ptr] = sh;
					ptr = ptr + 11'h001;
					wrote = 1'b1;
				end
				phase = ack ? phase + 1 : phase;
				sda_pull = ack;
			end else if (rd_mode && b > 0) begin
				sda_pull = ~mem[ptr][7 - b];
			end
		end
	end
endmodule

// [tb/nvc_controller_test.sv]
// Self-checking bench for the serial memory access controller
`timescale 1ns/1ps
module nvc_controller_test;
	import nvc_pkg::*;
	typedef struct packed {
		logic ws;
		logic rs;
		logic [7:0] lo;
		logic [7:0] hi;
		logic [7:0] d;
	} nvc_row_t;
	localparam logic [31:0] BASE = 32'h0010_0000;
	localparam nvc_row_t ROWS [2] = '{'{1'b0, 1'b1, 8'h23, 8'hF9, 8'h5A},
		'{1'b1, 1'b0, 8'hFF, 8'h07, 8'hC3}};
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	nvc_req_t hreq = '0;
	nvc_req_t areq = '0;
	nvc_rom_req_t rreq = '0;
	logic rom_en = 1'b0;
	logic nak = 1'b1;
	logic [31:0] host_rdata, addon_rdata, rom_data, v;
	logic rom_retry, rom_trdy, rom_wr_ack, boot_done, boot_fail, scl_oe, sda_oe, sda_pull;
	int err_total = 0;
	int compares = 0;
	// Open-drain lines with pull-ups
	wire scl = ~scl_oe;
	wire sda = ~(sda_oe | sda_pull);
	nvc_controller u_nvc_controller (.core_clk(core_clk), .rst_n(rst_n), .host_req(hreq),
		.host_rdata(host_rdata), .addon_req(areq), .addon_rdata(addon_rdata),
		.rom_enable(rom_en), .rom_base(BASE), .rom_req(rreq), .rom_retry(rom_retry),
		.rom_trdy(rom_trdy), .rom_wr_ack(rom_wr_ack), .rom_data(rom_data), .cfg_valid(),
		.cfg_addr(), .cfg_data(), .boot_done(boot_done), .boot_fail(boot_fail), .scl_in(scl),
		.scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe));
	nvc_mem_model u_nvc_mem_model (.scl(scl), .sda(sda), .nak_all(nak), .sda_pull(sda_pull));
	// --------
	// Tasks
	// --------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		if (err_total == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// One request pulse; the leading edge keeps back-to-back pulses apart
	task automatic pulse(input logic s, input nvc_req_t r);
		@(posedge core_clk);
		#1;
		if (s) begin
			areq = r;
		end else begin
			hreq = r;
		end
		@(posedge core_clk);
		#1;
		hreq = '0;
		areq = '0;
	endtask
	task automatic cmd(input logic s, input logic [3:0] be, input logic [2:0] c,
		input logic [7:0] d);
		pulse(s, '{1'b1, 1'b0, NVC_REG_OFS, be, {c, 5'h00, d, 16'h0000}});
	endtask
	// Add-on answers come two cycles later than host answers
	task automatic reg_rd(input logic s, input logic [7:0] a, output logic [31:0] d);
		pulse(s, '{1'b0, 1'b1, a, 4'hF, 32'h0});
		repeat (s ? 3 : 1) @(posedge core_clk);
		#1;
		d = s ? addon_rdata : host_rdata;
	endtask
	task automatic wait_idle(input logic s, output logic [31:0] d);
		d = 32'hFFFF_FFFF;
		for (int i = 0; i < 400 && d[31] !== 1'b0; i++) begin
			repeat (250) @(posedge core_clk);
			reg_rd(s, NVC_REG_OFS, d);
		end
		check(d[31], 1'b0);
	endtask
	task automatic rom_cyc(input logic w, input logic [31:0] a, input logic [2:0] exp);
		@(posedge core_clk);
		#1;
		rreq = '{~w, w, a};
		@(posedge core_clk);
		#1;
		rreq = '0;
		check({rom_retry, rom_trdy, rom_wr_ack}, exp);
	endtask
	// --------
	// Sequence
	// --------
	initial begin
		forever #4 core_clk = ~core_clk;
	end
	// Watchdog sized for a boot download cut short by a silent memory plus every scenario
	initial begin
		repeat (150000) @(posedge core_clk);
		err_total++;
		$display("unexpected at %0t: watchdog expired", $time);
		stop_test();
	end
	initial begin
		repeat (8) @(posedge core_clk);
		check({scl_oe, sda_oe, rom_retry, rom_trdy}, 4'h0);
		#1;
		rst_n = 1'b1;
		// Memory silent at boot, so the download ends early
		for (int i = 0; i < 20000 && boot_done !== 1'b1; i++) @(posedge core_clk);
		check(boot_fail, 1'b1);
		#1;
		nak = 1'b0;
		reg_rd(1'b0, 8'h38, v);
		check(v, 32'h0);
		reg_rd(1'b1, 8'h40, v);
		check(v, 32'h0);
		// Word-wide write on one side, read back from the other
		for (int i = 0; i < 2; i++) begin
			wait_idle(ROWS[i].ws, v);
			cmd(ROWS[i].ws, 4'hC, NVC_CMD_LOAD_LO, ROWS[i].lo);
			cmd(ROWS[i].ws, 4'hC, NVC_CMD_LOAD_HI, ROWS[i].hi);
			cmd(ROWS[i].ws, 4'hC, NVC_CMD_BEGIN_WR, ROWS[i].d);
			reg_rd(ROWS[i].ws, NVC_REG_OFS, v);
			check(v[31], 1'b1);
			wait_idle(ROWS[i].ws, v);
			check(u_nvc_mem_model.mem[{ROWS[i].hi[2:0], ROWS[i].lo}], ROWS[i].d);
			cmd(ROWS[i].rs, 4'hC, NVC_CMD_LOAD_LO, ROWS[i].lo);
			cmd(ROWS[i].rs, 4'hC, NVC_CMD_LOAD_HI, ROWS[i].hi);
			cmd(ROWS[i].rs, 4'h8, NVC_CMD_BEGIN_RD, 8'h00);
			wait_idle(ROWS[i].rs, v);
			check(v[28:16], {5'h00, ROWS[i].d});
			check({scl_oe, sda_oe}, 2'h0);
		end
		// Byte-wide: command lane and data lane in separate writes
		cmd(1'b0, 4'h8, NVC_CMD_LOAD_LO, 8'h00);
		cmd(1'b0, 4'h4, 3'h0, 8'h10);
		cmd(1'b0, 4'h4, 3'h0, 8'h11);
		cmd(1'b0, 4'h8, NVC_CMD_LOAD_HI, 8'h00);
		cmd(1'b0, 4'h4, 3'h0, 8'hFA);
		cmd(1'b0, 4'h8, 3'h2, 8'h00);
		cmd(1'b0, 4'h4, 3'h0, 8'h77);
		cmd(1'b0, 4'h8, NVC_CMD_BEGIN_WR, 8'h00);
		wait_idle(1'b0, v);
		check(u_nvc_mem_model.mem[11'h211], 8'h77);
		check(u_nvc_mem_model.mem[11'h210], 8'h10 ^ 8'hA5);
		// Memory silent: the read fails and the flag shows it
		nak = 1'b1;
		cmd(1'b0, 4'hC, NVC_CMD_LOAD_LO, 8'h41);
		cmd(1'b0, 4'hC, NVC_CMD_LOAD_HI, 8'h00);
		cmd(1'b0, 4'h8, NVC_CMD_BEGIN_RD, 8'h00);
		wait_idle(1'b0, v);
		check(v[28], 1'b1);
		nak = 1'b0;
		// Window: disabled, write dropped, retries, a register read queued behind the fetch
		rom_cyc(1'b0, BASE + 32'h40, 3'h0);
		rom_en = 1'b1;
		rom_cyc(1'b1, BASE + 32'h40, 3'h1);
		rom_cyc(1'b0, BASE + 32'h40, 3'h4);
		cmd(1'b0, 4'h8, NVC_CMD_BEGIN_RD, 8'h00);
		rom_cyc(1'b0, BASE + 32'h44, 3'h4);
		rom_cyc(1'b0, BASE + 32'h40, 3'h4);
		wait_idle(1'b0, v);
		check(v[28:16], {5'h00, 8'h41 ^ 8'hA5});
		rom_cyc(1'b0, BASE + 32'h48, 3'h4);
		rom_cyc(1'b0, BASE + 32'h40, 3'h2);
		check(rom_data, 32'h4342_4140 ^ 32'hA5A5_A5A5);
		stop_test();
	end
endmodule
